// [logic/sirc_pkg.sv]
package sirc_pkg;
    // Register indices
    localparam logic [15:0] ADDR_TBL_CMD = 16'h1811;
    localparam logic [15:0] ADDR_TBL_WDATA = 16'h1812;
    localparam logic [15:0] ADDR_TBL_RDATA = 16'h1813;
    localparam logic [15:0] ADDR_TBL_STATUS = 16'h1814;
    localparam logic [15:0] ADDR_GLOBAL_CFG = 16'h1840;
    localparam logic [15:0] ADDR_PORT_CFG = 16'h1841;
    localparam logic [15:0] ADDR_PORT_STATE = 16'h1843;
    localparam logic [15:0] ADDR_ADMIT = 16'h1850;
    // Global ingress config fields
    localparam int G_VLAN_EN = 0;
    localparam int G_VL_HIGHER = 1;
    localparam int G_USE_PREC = 2;
    localparam int G_DROP_UNK = 3;
    localparam int G_FILT_MC = 4;
    localparam int G_DA_HIGHEST = 5;
    localparam int G_CNT_TEST = 6;
    localparam int G_IGMP_EN = 7;
    localparam int G_USE_IP = 9;
    localparam int G_IGMP_LSB = 10;
    localparam int G_ECHO = 13;
    localparam int G_WIDTH = 14;
    localparam logic [13:0] G_RESET = 14'h0006;
    // Per-port config fields
    localparam int P_LEARN_LSB = 3;
    localparam logic [5:0] P_RESET = 6'h38;
    localparam logic [5:0] STATE_RESET = 6'h00;
    localparam logic [2:0] ADMIT_RESET = 3'h0;
    // Table command fields
    localparam int C_RNW = 7;
    localparam logic [7:0] C_MASK = 8'hBF;
    localparam int TBL_IDX_W = 6;
    localparam int TBL_PRI_W = 3;
    localparam logic [3:0] TBL_ACCESS_CYCLES = 4'h2;
    // Spanning tree states
    localparam logic [1:0] STP_FORWARD = 2'h0;
    localparam logic [1:0] STP_BLOCK = 2'h1;
    localparam logic [1:0] STP_LEARN = 2'h2;
    localparam logic [1:0] STP_LISTEN = 2'h3;
    // Counter read pattern in test mode
    localparam logic [31:0] CNT_TEST_PATTERN = 32'h07FF_FFFC;
    // Table access states
    typedef enum logic [1:0] {
        SIRC_TBL_IDLE = 2'b01,
        SIRC_TBL_BUSY = 2'b10
    } sirc_tbl_state_t;
endpackage

// [logic/sirc_top.sv]
`timescale 1ns/1ps
module sirc_top #(
    parameter int NUM_PORTS = 3,
    parameter int TBL_DEPTH = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Packet descriptor from the forwarding engine
    input wire logic pkt_valid,
    input wire logic [1:0] pkt_port,
    input wire logic pkt_da_found,
    input wire logic pkt_da_static,
    input wire logic [2:0] pkt_da_pri,
    input wire logic [NUM_PORTS-1:0] pkt_da_ports,
    input wire logic pkt_mcast,
    input wire logic pkt_bcast,
    input wire logic pkt_tagged,
    input wire logic [2:0] pkt_vlan_pri,
    input wire logic [NUM_PORTS-1:0] pkt_vlan_members,
    input wire logic pkt_ipv4,
    input wire logic pkt_ipv6,
    input wire logic [7:0] pkt_tos,
    input wire logic pkt_igmp,
    input wire logic [2:0] pkt_default_pri,
    // Decision to the forwarding engine
    output logic res_valid,
    output logic res_drop,
    output logic [NUM_PORTS-1:0] res_dest,
    output logic [2:0] res_pri,
    output logic res_learn,
    // Statistics counter read hook
    input wire logic cnt_rd,
    output logic [31:0] cnt_after_read
);
    import sirc_pkg::*;

    // Elaboration guard, the logic serves three ports and a 64-entry table
    if (NUM_PORTS != 3 || TBL_DEPTH != 64) begin : g_bad_size
        $error("sirc_top supports three ports and a 64-entry table only");
    end

    // Port bit pick
    function automatic logic port_bit(input logic [2:0] vec, input logic [1:0] idx);
        port_bit = (idx < 2'd3) ? vec[idx] : 1'b0;
    endfunction

    logic [G_WIDTH-1:0] global_ingress_config;
    logic [5:0] per_port_ingress_config;
    logic [5:0] spanning_tree_state_reg;
    logic [2:0] admit_non_member_reg;
    logic [7:0] priority_table_command;
    logic [TBL_PRI_W-1:0] tbl_wdata;
    logic [TBL_PRI_W-1:0] tbl_rdata;
    logic [TBL_PRI_W-1:0] prio_tbl [TBL_DEPTH];
    sirc_tbl_state_t tbl_state;
    sirc_tbl_state_t next_tbl_state;
    logic [3:0] tbl_cnt;
    logic pending;

    // Register write decode
    wire wr_global = reg_wr && reg_addr == ADDR_GLOBAL_CFG;
    wire wr_port = reg_wr && reg_addr == ADDR_PORT_CFG;
    wire wr_state = reg_wr && reg_addr == ADDR_PORT_STATE;
    wire wr_admit = reg_wr && reg_addr == ADDR_ADMIT;
    wire wr_wdata = reg_wr && reg_addr == ADDR_TBL_WDATA;
    wire wr_cmd = reg_wr && reg_addr == ADDR_TBL_CMD;
    wire tbl_start = wr_cmd && tbl_state == SIRC_TBL_IDLE;
    wire tbl_done = tbl_state == SIRC_TBL_BUSY && tbl_cnt == 4'h1;
    wire [TBL_IDX_W-1:0] tbl_idx = priority_table_command[TBL_IDX_W-1:0];

    // Configuration registers, bits above each register's width never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            global_ingress_config <= G_RESET;
            per_port_ingress_config <= P_RESET;
            spanning_tree_state_reg <= STATE_RESET;
            admit_non_member_reg <= ADMIT_RESET;
            tbl_wdata <= '0;
        end else begin
            if (wr_global) global_ingress_config <= reg_wdata[G_WIDTH-1:0];
            if (wr_port) per_port_ingress_config <= reg_wdata[5:0];
            if (wr_state) spanning_tree_state_reg <= reg_wdata[5:0];
            if (wr_admit) admit_non_member_reg <= reg_wdata[2:0];
            if (wr_wdata) tbl_wdata <= reg_wdata[TBL_PRI_W-1:0];
        end
    end

    // Table access sequencer
    always_comb begin
        next_tbl_state = tbl_state;
        unique case (tbl_state)
            SIRC_TBL_IDLE: if (tbl_start) next_tbl_state = SIRC_TBL_BUSY;
            SIRC_TBL_BUSY: if (tbl_done) next_tbl_state = SIRC_TBL_IDLE;
            default: next_tbl_state = SIRC_TBL_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tbl_state <= SIRC_TBL_IDLE;
            tbl_cnt <= '0;
            priority_table_command <= '0;
        end else begin
            tbl_state <= next_tbl_state;
            if (tbl_start) begin
                priority_table_command <= reg_wdata[7:0] & C_MASK;
                tbl_cnt <= TBL_ACCESS_CYCLES;
            end else if (tbl_cnt != 4'h0) begin
                tbl_cnt <= tbl_cnt - 4'h1;
            end
        end
    end

    assign pending = tbl_state == SIRC_TBL_BUSY;

    // Table storage, written or read at the end of an access
    always_ff @(posedge clk) begin
        if (tbl_done && !priority_table_command[C_RNW]) prio_tbl[tbl_idx] <= tbl_wdata;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) tbl_rdata <= '0;
        else if (tbl_done && priority_table_command[C_RNW]) tbl_rdata <= prio_tbl[tbl_idx];
    end

    // Register read mux, reserved bits zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr)
            ADDR_TBL_CMD: next_rdata[7:0] = priority_table_command;
            ADDR_TBL_WDATA: next_rdata[TBL_PRI_W-1:0] = tbl_wdata;
            ADDR_TBL_RDATA: next_rdata[TBL_PRI_W-1:0] = tbl_rdata;
            ADDR_TBL_STATUS: next_rdata[0] = pending;
            ADDR_GLOBAL_CFG: next_rdata[G_WIDTH-1:0] = global_ingress_config;
            ADDR_PORT_CFG: next_rdata[5:0] = per_port_ingress_config;
            ADDR_PORT_STATE: next_rdata[5:0] = spanning_tree_state_reg;
            ADDR_ADMIT: next_rdata[2:0] = admit_non_member_reg;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= '0;
        else if (reg_rd) reg_rdata <= next_rdata;
    end

    // Global control bits
    wire vlan_en = global_ingress_config[G_VLAN_EN];
    wire vl_higher = global_ingress_config[G_VL_HIGHER];
    wire use_prec = global_ingress_config[G_USE_PREC];
    wire drop_unk = global_ingress_config[G_DROP_UNK];
    wire filt_mc = global_ingress_config[G_FILT_MC];
    wire da_highest = global_ingress_config[G_DA_HIGHEST];
    wire cnt_test = global_ingress_config[G_CNT_TEST];
    wire igmp_en = global_ingress_config[G_IGMP_EN];
    wire use_ip = global_ingress_config[G_USE_IP];
    wire [2:0] igmp_ports = global_ingress_config[G_IGMP_LSB +: 3];
    wire echo_en = global_ingress_config[G_ECHO];

    // Per-packet port attributes
    wire [2:0] src_map = 3'h1 << pkt_port;
    wire [1:0] port_state = spanning_tree_state_reg[2*pkt_port +: 2];
    wire learn_bit = port_bit(per_port_ingress_config[P_LEARN_LSB +: 3], pkt_port);
    wire check_bit = port_bit(per_port_ingress_config[2:0], pkt_port);
    wire admit_bit = port_bit(admit_non_member_reg, pkt_port);
    wire ingress_member = port_bit(pkt_vlan_members, pkt_port);

    // Learning qualification
    wire learn_ok = learn_bit && (port_state == STP_FORWARD || port_state == STP_LEARN);

    // Unknown destination filters
    wire unk_uc_drop = drop_unk && !pkt_da_found && !pkt_mcast && !pkt_bcast;
    wire unk_mc_drop = filt_mc && !pkt_da_found && pkt_mcast && !pkt_bcast;

    // Group-management monitoring and destination set
    wire igmp_hit = igmp_en && pkt_ipv4 && pkt_igmp;
    wire [2:0] base_dest = pkt_da_found ? pkt_da_ports : 3'h7;
    wire [2:0] sel_dest = igmp_hit ? igmp_ports : base_dest;
    wire echo_ok = igmp_hit && echo_en;
    wire [2:0] final_dest = echo_ok ? sel_dest : (sel_dest & ~src_map);

    // VLAN membership checks
    wire check_on = vlan_en && check_bit;
    wire ingress_fail = check_on && !ingress_member && !admit_bit;
    wire egress_fail = check_on && pkt_da_found && |(final_dest & ~pkt_vlan_members);
    wire drop_now = unk_uc_drop || unk_mc_drop || ingress_fail || egress_fail;

    // Transmit priority selection
    wire [2:0] ip_pri = (pkt_ipv4 && use_prec) ? pkt_tos[7:5] : prio_tbl[pkt_tos[7:2]];
    wire ip_ok = use_ip && (pkt_ipv4 || pkt_ipv6);
    wire vlan_ok = vlan_en && pkt_tagged;
    wire da_ok = da_highest && pkt_da_found && pkt_da_static;
    logic [2:0] pick_pri;
    always_comb begin
        pick_pri = pkt_default_pri;
        if (da_ok) pick_pri = pkt_da_pri;
        else if (vlan_ok && (vl_higher || !ip_ok)) pick_pri = pkt_vlan_pri;
        else if (ip_ok) pick_pri = ip_pri;
    end

    // Registered decision
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_drop <= 1'b0;
            res_dest <= '0;
            res_pri <= '0;
            res_learn <= 1'b0;
        end else begin
            res_valid <= pkt_valid;
            if (pkt_valid) begin
                res_drop <= drop_now;
                res_dest <= drop_now ? 3'h0 : final_dest;
                res_pri <= pick_pri;
                res_learn <= learn_ok;
            end
        end
    end

    // Value a clear-on-read counter takes after a read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_after_read <= '0;
        else if (cnt_rd) cnt_after_read <= cnt_test ? CNT_TEST_PATTERN : 32'h0000_0000;
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [2:0] src_q;
    logic echo_q;
    logic igmp_q;
    logic [2:0] igmp_ports_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= '0;
            echo_q <= 1'b0;
            igmp_q <= 1'b0;
            igmp_ports_q <= '0;
        end else if (pkt_valid) begin
            src_q <= src_map;
            echo_q <= echo_ok;
            igmp_q <= igmp_hit && !drop_now;
            igmp_ports_q <= igmp_ports;
        end
    end

    sequence s_cmd_taken;
        reg_wr && reg_addr == ADDR_TBL_CMD && !pending;
    endsequence
    sequence s_busy_then_free;
        pending [*2] ##1 !pending;
    endsequence

    // Command written while an access runs
    sequence s_cmd_refused;
        reg_wr && reg_addr == ADDR_TBL_CMD && pending;
    endsequence
    sequence s_cmd_held;
        $stable(priority_table_command);
    endsequence

    // Table access checks
    a_pending_sequence: assert property (s_cmd_taken |=> s_busy_then_free)
        else $error("pending flag did not span the table access");

    a_busy_cmd_ignored: assert property (s_cmd_refused |=> s_cmd_held)
        else $error("table command changed during an access");

    a_cmd_capture: assert property (s_cmd_taken
        |=> priority_table_command == ($past(reg_wdata[7:0]) & C_MASK))
        else $error("table command not captured");

    // Reserved bit checks
    a_status_reserved: assert property (reg_rd && reg_addr == ADDR_TBL_STATUS
        |=> reg_rdata[31:1] == 31'h0 && reg_rdata[0] == $past(pending))
        else $error("status read returned wrong bits");

    a_cfg_reserved: assert property (reg_rd && reg_addr == ADDR_GLOBAL_CFG
        |=> reg_rdata[31:G_WIDTH] == 18'h0)
        else $error("global config read shows reserved bits");

    a_port_reserved: assert property (reg_rd && reg_addr == ADDR_PORT_CFG
        |=> reg_rdata[31:6] == 26'h0)
        else $error("port config read shows reserved bits");

    // Destination checks
    a_no_echo_src: assert property (res_valid && !echo_q |-> (res_dest & src_q) == 3'h0)
        else $error("packet sent back to source port");

    a_igmp_dest_map: assert property (res_valid && igmp_q
        |-> res_dest == (echo_q ? igmp_ports_q : (igmp_ports_q & ~src_q)))
        else $error("monitored packet not sent to monitoring ports");

    a_igmp_redirect: assert property (pkt_valid && igmp_en && pkt_ipv4 && pkt_igmp
        && echo_en && !drop_now |=> res_dest == $past(igmp_ports))
        else $error("group-management packet not redirected");

    // Filter checks
    a_unknown_uc_drop: assert property (pkt_valid && drop_unk && !pkt_da_found
        && !pkt_mcast && !pkt_bcast |=> res_valid && res_drop)
        else $error("unknown unicast not dropped");

    a_unknown_mc_drop: assert property (pkt_valid && filt_mc && !pkt_da_found
        && pkt_mcast && !pkt_bcast |=> res_valid && res_drop)
        else $error("unknown multicast not dropped");

    a_bcast_exempt: assert property (pkt_valid && pkt_bcast && !vlan_en |=> !res_drop)
        else $error("broadcast dropped by address filter");

    a_drop_no_dest: assert property (res_valid && res_drop |-> res_dest == 3'h0)
        else $error("dropped packet still has destinations");

    // Membership checks
    a_member_ignored: assert property (pkt_valid && !vlan_en && !drop_unk && !filt_mc
        |=> !res_drop)
        else $error("membership checked with VLANs off");

    a_ingress_member: assert property (pkt_valid && vlan_en && check_bit
        && !ingress_member && !admit_bit |=> res_drop)
        else $error("non-member ingress not dropped");

    a_egress_member: assert property (pkt_valid && check_on && pkt_da_found && !igmp_hit
        && |(pkt_da_ports & ~src_map & ~pkt_vlan_members) |=> res_drop)
        else $error("non-member egress not dropped");

    // Learning checks
    a_learn_blocked: assert property (pkt_valid && (port_state == STP_BLOCK
        || port_state == STP_LISTEN) |=> !res_learn)
        else $error("learning in blocking or listening state");

    a_learn_state: assert property (pkt_valid && learn_bit && port_state == STP_LEARN
        |=> res_learn)
        else $error("no learning in learning state");

    a_learn_off: assert property (pkt_valid && !learn_bit |=> !res_learn)
        else $error("learning with port learn bit clear");

    // Counter checks
    a_counter_pattern: assert property (cnt_rd && cnt_test
        |=> cnt_after_read == CNT_TEST_PATTERN)
        else $error("counter test pattern not loaded");

    a_counter_clear: assert property (cnt_rd && !cnt_test
        |=> cnt_after_read == 32'h0000_0000)
        else $error("counter not cleared on read");

    // Priority checks
    a_da_priority: assert property (pkt_valid && da_ok |=> res_pri == $past(pkt_da_pri))
        else $error("static entry priority not used");

    a_vlan_pri_first: assert property (pkt_valid && !da_ok && vlan_ok && vl_higher
        |=> res_pri == $past(pkt_vlan_pri))
        else $error("tag priority not preferred");

    a_ip_pri_first: assert property (pkt_valid && !da_ok && vlan_ok && !vl_higher
        && use_ip && pkt_ipv4 && use_prec |=> res_pri == $past(pkt_tos[7:5]))
        else $error("IP priority not preferred");

    a_ip_precedence: assert property (pkt_valid && !da_ok && !vlan_ok && use_ip
        && pkt_ipv4 && use_prec |=> res_pri == $past(pkt_tos[7:5]))
        else $error("precedence bits not used");

    a_ip_gated: assert property (pkt_valid && !da_ok && !vlan_ok && !use_ip
        |=> res_pri == $past(pkt_default_pri))
        else $error("IP priority used while disabled");

    a_vlan_off_pri: assert property (pkt_valid && !vlan_en && pkt_tagged && !da_ok
        && !ip_ok |=> res_pri == $past(pkt_default_pri))
        else $error("tag priority used with VLANs off");
endmodule

// [tb/sirc_fwd_model.sv]
`timescale 1ns/1ps
module sirc_fwd_model (
    // Clock
    input wire logic clk,
    // Descriptor towards the rule block
    output logic pkt_valid,
    output logic [1:0] pkt_port,
    output logic pkt_da_found,
    output logic pkt_da_static,
    output logic [2:0] pkt_da_pri,
    output logic [2:0] pkt_da_ports,
    output logic pkt_mcast,
    output logic pkt_bcast,
    output logic pkt_tagged,
    output logic [2:0] pkt_vlan_pri,
    output logic [2:0] pkt_vlan_members,
    output logic pkt_ipv4,
    output logic pkt_ipv6,
    output logic [7:0] pkt_tos,
    output logic pkt_igmp,
    output logic [2:0] pkt_default_pri,
    // Decision coming back
    input wire logic res_valid,
    input wire logic res_drop,
    input wire logic [2:0] res_dest,
    input wire logic [2:0] res_pri,
    input wire logic res_learn
);
    // Idle descriptor, fixed fallback priority
    initial begin
        {pkt_valid, pkt_port, pkt_da_found, pkt_da_static, pkt_da_pri, pkt_da_ports} = '0;
        {pkt_mcast, pkt_bcast, pkt_tagged, pkt_vlan_pri, pkt_vlan_members} = '0;
        {pkt_ipv4, pkt_ipv6, pkt_tos, pkt_igmp} = '0;
        pkt_default_pri = 3'h1;
    end

    // One descriptor; decision returned as {drop, dest, pri, learn}
    task automatic send(input logic [1:0] p, input logic [3:0] f, input logic [5:0] da,
                        input logic [3:0] vt, input logic [2:0] mem, input logic [2:0] ip,
                        input logic [7:0] tos, output logic [7:0] r);
        @(posedge clk);
        pkt_valid <= 1'b1;
        {pkt_port, pkt_da_found, pkt_da_static, pkt_mcast, pkt_bcast} <= {p, f};
        {pkt_da_pri, pkt_da_ports, pkt_tagged, pkt_vlan_pri} <= {da, vt};
        {pkt_vlan_members, pkt_ipv4, pkt_ipv6, pkt_igmp, pkt_tos} <= {mem, ip, tos};
        @(posedge clk);
        pkt_valid <= 1'b0;
        pkt_tos <= ~tos;  // Stale fields must not linger
        pkt_vlan_members <= ~mem;
        #1;
        r = res_valid ? {res_drop, res_dest, res_pri, res_learn} : 8'hXX;
    endtask
endmodule

// [tb/switch_ingress_rule_control_tb.sv]
`timescale 1ns/1ps
module switch_ingress_rule_control_tb;
    import sirc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cnt_rd = 1'b0;
    logic [31:0] reg_rdata, cnt_after_read;
    logic pkt_valid, pkt_da_found, pkt_da_static, pkt_mcast, pkt_bcast, pkt_tagged;
    logic pkt_ipv4, pkt_ipv6, pkt_igmp, res_valid, res_drop, res_learn;
    logic [1:0] pkt_port;
    logic [2:0] pkt_da_pri, pkt_da_ports, pkt_vlan_pri, pkt_vlan_members, pkt_default_pri;
    logic [2:0] res_dest, res_pri;
    logic [7:0] pkt_tos;
    int mismatches = 0;
    int n_compared = 0;

    // Block and its forwarding-side partner
    sirc_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pkt_valid, .pkt_port, .pkt_da_found, .pkt_da_static, .pkt_da_pri, .pkt_da_ports,
        .pkt_mcast, .pkt_bcast, .pkt_tagged, .pkt_vlan_pri, .pkt_vlan_members, .pkt_ipv4,
        .pkt_ipv6, .pkt_tos, .pkt_igmp, .pkt_default_pri, .res_valid, .res_drop, .res_dest,
        .res_pri, .res_learn, .cnt_rd, .cnt_after_read);
    sirc_fwd_model fwd (.clk, .pkt_valid, .pkt_port, .pkt_da_found, .pkt_da_static,
        .pkt_da_pri, .pkt_da_ports, .pkt_mcast, .pkt_bcast, .pkt_tagged, .pkt_vlan_pri,
        .pkt_vlan_members, .pkt_ipv4, .pkt_ipv6, .pkt_tos, .pkt_igmp, .pkt_default_pri,
        .res_valid, .res_drop, .res_dest, .res_pri, .res_learn);

    // 20 MHz clock
    always #25 clk = ~clk;

    // Compare and verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Register bus cycles
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rc(input string nm, input logic [15:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(nm, e, d);
    endtask
    task automatic wait_idle;
        logic [31:0] d;
        for (int i = 0; i < 8; i++) begin
            rd(ADDR_TBL_STATUS, d);
            if (d[0] === 1'b0) break;
        end
        chk("pending clear", 32'h0, d);
    endtask
    // Packet through the partner, masked decision compared
    task automatic pk(input string nm, input logic [7:0] m, input logic [7:0] e,
                      input logic [1:0] p, input logic [3:0] f, input logic [5:0] da,
                      input logic [3:0] vt, input logic [2:0] mem, input logic [2:0] ip,
                      input logic [7:0] tos);
        logic [7:0] r;
        fwd.send(p, f, da, vt, mem, ip, tos, r);
        chk(nm, {24'h0, e}, {24'h0, r & m});
    endtask
    task automatic cnt(input logic [31:0] e);
        @(posedge clk);
        cnt_rd <= 1'b1;
        @(posedge clk);
        cnt_rd <= 1'b0;
        #1 chk("cnt", e, cnt_after_read);
    endtask

    // Scenarios
    task automatic t_reset;
        rc("global", ADDR_GLOBAL_CFG, 32'h6);
        rc("portcfg", ADDR_PORT_CFG, 32'h38);
        rc("status", ADDR_TBL_STATUS, 32'h0);
        rc("state", ADDR_PORT_STATE, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_reserved;
        wr(ADDR_GLOBAL_CFG, 32'hFFFF_FFFF);
        rc("global rsv", ADDR_GLOBAL_CFG, 32'h3FFF);
        wr(ADDR_PORT_CFG, 32'hFFFF_FFFF);
        rc("portcfg rsv", ADDR_PORT_CFG, 32'h3F);
        wr(ADDR_TBL_STATUS, 32'hFFFF_FFFF);
        rc("status ro", ADDR_TBL_STATUS, 32'h0);
        rc("unmapped", 16'h1830, 32'h0);
        wr(ADDR_GLOBAL_CFG, 32'h6);
        wr(ADDR_PORT_CFG, 32'h38);
        $display("test reserved done");
    endtask
    task automatic t_table;
        logic [31:0] d;
        wr(ADDR_TBL_WDATA, 32'h5);
        wr(ADDR_TBL_CMD, 32'h0A);
        rd(ADDR_TBL_STATUS, d);
        chk("pending set", 32'h1, d);
        wait_idle();
        wr(ADDR_TBL_CMD, 32'h8A);
        wait_idle();
        rc("tbl data", ADDR_TBL_RDATA, 32'h5);
        rc("tbl cmd", ADDR_TBL_CMD, 32'h8A);
        wr(ADDR_GLOBAL_CFG, 32'h200);
        pk("tbl pri", 8'h0E, 8'h0A, 0, 4'h0, 6'h0, 4'h0, 3'h7, 3'b100, 8'h28);
        $display("test table done");
    endtask
    task automatic t_filter;
        wr(ADDR_GLOBAL_CFG, 32'h1E);
        pk("unk uc", 8'hF0, 8'h80, 0, 4'b0000, 6'h0, 4'h0, 3'h7, 3'h0, 8'h0);
        pk("unk mc", 8'hF0, 8'h80, 0, 4'b0010, 6'h0, 4'h0, 3'h7, 3'h0, 8'h0);
        pk("bcast", 8'hF0, 8'h50, 1, 4'b0011, 6'h0, 4'h0, 3'h7, 3'h0, 8'h0);
        pk("known uc", 8'hF0, 8'h40, 0, 4'b1000, 6'h4, 4'h0, 3'h7, 3'h0, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h6);
        pk("no filter", 8'hF0, 8'h60, 0, 4'b0000, 6'h0, 4'h0, 3'h7, 3'h0, 8'h0);
        $display("test filter done");
    endtask
    task automatic t_priority;
        wr(ADDR_GLOBAL_CFG, 32'h26);
        pk("static", 8'h0E, 8'h0C, 0, 4'b1100, 6'h32, 4'h0, 3'h7, 3'h0, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h207);
        pk("vl higher", 8'h0E, 8'h08, 0, 4'h0, 6'h0, 4'hC, 3'h7, 3'b100, 8'hE0);
        wr(ADDR_GLOBAL_CFG, 32'h205);
        pk("ip higher", 8'h0E, 8'h0E, 0, 4'h0, 6'h0, 4'hC, 3'h7, 3'b100, 8'hE0);
        wr(ADDR_GLOBAL_CFG, 32'h206);
        pk("vlan off", 8'h0E, 8'h0E, 0, 4'h0, 6'h0, 4'hC, 3'h7, 3'b100, 8'hE0);
        wr(ADDR_GLOBAL_CFG, 32'h6);
        pk("default", 8'h0E, 8'h02, 0, 4'h0, 6'h0, 4'hC, 3'h7, 3'b100, 8'hE0);
        $display("test priority done");
    endtask
    task automatic t_igmp;
        wr(ADDR_GLOBAL_CFG, 32'h0C86);
        pk("igmp map", 8'h70, 8'h20, 0, 4'h0, 6'h0, 4'h0, 3'h7, 3'b101, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h2C86);
        pk("igmp echo", 8'h70, 8'h30, 0, 4'h0, 6'h0, 4'h0, 3'h7, 3'b101, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h0C06);
        pk("igmp off", 8'h70, 8'h60, 0, 4'h0, 6'h0, 4'h0, 3'h7, 3'b101, 8'h0);
        $display("test igmp done");
    endtask
    task automatic t_member;
        wr(ADDR_PORT_CFG, 32'h3F);
        wr(ADDR_GLOBAL_CFG, 32'h7);
        pk("non member", 8'hF0, 8'h80, 1, 4'h0, 6'h0, 4'h0, 3'b101, 3'h0, 8'h0);
        wr(ADDR_ADMIT, 32'h2);
        pk("admit", 8'hF0, 8'h50, 1, 4'h0, 6'h0, 4'h0, 3'b101, 3'h0, 8'h0);
        wr(ADDR_ADMIT, 32'h0);
        pk("egress", 8'hF0, 8'h80, 1, 4'b1000, 6'h4, 4'h0, 3'b011, 3'h0, 8'h0);
        pk("unk egress", 8'hF0, 8'h50, 1, 4'h0, 6'h0, 4'h0, 3'b010, 3'h0, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h6);
        pk("global off", 8'hF0, 8'h50, 1, 4'h0, 6'h0, 4'h0, 3'b101, 3'h0, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h7);
        wr(ADDR_PORT_CFG, 32'h38);
        pk("port off", 8'hF0, 8'h50, 1, 4'h0, 6'h0, 4'h0, 3'b101, 3'h0, 8'h0);
        wr(ADDR_GLOBAL_CFG, 32'h6);
        $display("test member done");
    endtask
    task automatic t_learn;
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_PORT_STATE, 32'(s));
            pk("learn st", 8'h01, 8'((s % 2) == 0), 0, 4'h0, 6'h0, 4'h0, 3'h7, 3'h0, 8'h0);
        end
        wr(ADDR_PORT_STATE, 32'h0);
        wr(ADDR_PORT_CFG, 32'h30);
        pk("learn off", 8'h01, 8'h00, 0, 4'h0, 6'h0, 4'h0, 3'h7, 3'h0, 8'h0);
        wr(ADDR_PORT_CFG, 32'h38);
        wr(ADDR_GLOBAL_CFG, 32'h46);
        cnt(32'h07FF_FFFC);
        wr(ADDR_GLOBAL_CFG, 32'h6);
        cnt(32'h0);
        $display("test learn and counter done");
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_reserved();
        t_table();
        t_filter();
        t_priority();
        t_igmp();
        t_member();
        t_learn();
        report_and_stop();
    end

    // Watchdog well beyond the expected 160 or so cycles
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
